//--- common/mis_pkg.sv
// Package: register map, field layout and timing of the IRQ summary / PHY management block
package mis_pkg;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [31:0] MIS_ADDR_CMD = 32'h8001_0010;
   localparam logic [31:0] MIS_ADDR_DATA = 32'h8001_0014;
   localparam logic [31:0] MIS_ADDR_STS = 32'h8001_0018;
   localparam logic [31:0] MIS_ADDR_GSTS = 32'h8001_0060;
   localparam logic [31:0] MIS_ADDR_GMSK = 32'h8001_0064;
   localparam logic [31:0] MIS_ADDR_GVIEW = 32'h8001_0068;
   localparam logic [31:0] MIS_ADDR_GFRC = 32'h8001_006c;
   localparam logic [31:0] MIS_RESET_WORD = 32'h0000_0000;

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int MIS_INT_BIT = 15;
   localparam int MIS_BUSY_BIT = 0;
   localparam int MIS_OP_HI = 15;
   localparam int MIS_OP_LO = 14;
   localparam int MIS_PHY_HI = 9;
   localparam int MIS_PHY_LO = 5;
   localparam int MIS_REG_HI = 4;
   localparam int MIS_REG_LO = 0;
   localparam int MIS_DATA_W = 16;
   localparam logic [15:0] MIS_CMD_MASK = 16'hc3ff;

   // ************************************************************
   // Opcodes and frame layout
   // ************************************************************
   localparam logic [1:0] MIS_OP_READ = 2'b10;
   localparam logic [1:0] MIS_OP_WRITE = 2'b01;
   localparam logic [1:0] MIS_FRAME_START = 2'b01;
   localparam logic [1:0] MIS_TA_WRITE = 2'b10;
   localparam logic [1:0] MIS_TA_IDLE = 2'b11;
   localparam logic [1:0] MIS_HTRANS_ACTIVE = 2'b10;
   localparam int MIS_PREAMBLE_BITS = 32;
   localparam logic [6:0] MIS_LAST_BIT = 7'h3f;
   localparam logic [6:0] MIS_TA_FIRST_BIT = 7'h2e;
   localparam logic [6:0] MIS_DATA_FIRST_BIT = 7'h30;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int MIS_CLK_PERIOD_NS = 50;
   localparam int MIS_MDC_PERIOD_NS = 400;
   localparam int MIS_MDC_HALF_CYC =
      ((MIS_MDC_PERIOD_NS / 2) + MIS_CLK_PERIOD_NS - 1) / MIS_CLK_PERIOD_NS;
   localparam logic [3:0] MIS_HALF_LAST = 4'(MIS_MDC_HALF_CYC - 1);

   typedef enum logic [1:0] {
      MIS_IDLE = 2'b00,
      MIS_SHIFT = 2'b01,
      MIS_DONE = 2'b10
   } mis_mdio_state_t;

endpackage : mis_pkg

//--- rtl/mis_mdio_engine.sv
// Serial management frame engine driving MDC and MDIO
`timescale 1ns/100ps
module mis_mdio_engine
   import mis_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic soft_rst,
   // Command side
   input wire logic start,
   input wire logic [1:0] op,
   input wire logic [4:0] phy_sel,
   input wire logic [4:0] reg_sel,
   input wire logic [MIS_DATA_W-1:0] wdata,
   output logic done,
   output logic rd_done,
   output logic [MIS_DATA_W-1:0] rdata,
   // Management pins
   output logic mdc,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic mdio_i
);

   mis_mdio_state_t state_q;
   logic [3:0] phase_q;
   logic [6:0] bit_q;
   logic [63:0] frame_q;
   logic mdc_q;
   logic oe_q;
   logic rd_op_q;
   logic [MIS_DATA_W-1:0] rd_q;
   logic mdio_s1_q;
   logic mdio_s2_q;
   logic half_end;

   // ************************************************************
   // Pin synchroniser
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mdio_s1_q <= 1'b0;
         mdio_s2_q <= 1'b0;
      end else begin
         mdio_s1_q <= mdio_i;
         mdio_s2_q <= mdio_s1_q;
      end
   end

   // ************************************************************
   // Frame sequencer
   // ************************************************************
   assign half_end = (phase_q == MIS_HALF_LAST);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= MIS_IDLE;
         phase_q <= 4'h0;
         bit_q <= 7'h00;
         frame_q <= 64'h0;
         mdc_q <= 1'b0;
         oe_q <= 1'b0;
         rd_op_q <= 1'b0;
         rd_q <= 16'h0000;
      end else if (soft_rst) begin
         state_q <= MIS_IDLE;
         phase_q <= 4'h0;
         bit_q <= 7'h00;
         frame_q <= 64'h0;
         mdc_q <= 1'b0;
         oe_q <= 1'b0;
         rd_op_q <= 1'b0;
         rd_q <= 16'h0000;
      end else begin
         unique case (state_q)
            MIS_IDLE: begin
               if (start && (op == MIS_OP_READ || op == MIS_OP_WRITE)) begin
                  // Preamble, start, opcode, addresses, turnaround, data
                  frame_q <= {{MIS_PREAMBLE_BITS{1'b1}}, MIS_FRAME_START, op, phy_sel,
                              reg_sel, (op == MIS_OP_WRITE) ? MIS_TA_WRITE : MIS_TA_IDLE,
                              (op == MIS_OP_WRITE) ? wdata : 16'hffff};
                  rd_op_q <= (op == MIS_OP_READ);
                  bit_q <= 7'h00;
                  phase_q <= 4'h0;
                  oe_q <= 1'b1;
                  state_q <= MIS_SHIFT;
               end else if (start) begin
                  // Undefined opcode: no frame, just finish so busy drops
                  rd_op_q <= 1'b0;
                  state_q <= MIS_DONE;
               end
            end
            MIS_SHIFT: begin
               phase_q <= half_end ? 4'h0 : phase_q + 4'h1;
               if (half_end && !mdc_q) begin
                  mdc_q <= 1'b1;
                  // PHY drives data valid around the rising edge
                  if (rd_op_q && bit_q >= MIS_DATA_FIRST_BIT) begin
                     rd_q <= {rd_q[MIS_DATA_W-2:0], mdio_s2_q};
                  end
               end else if (half_end) begin
                  mdc_q <= 1'b0;
                  if (bit_q == MIS_LAST_BIT) begin
                     oe_q <= 1'b0;
                     state_q <= MIS_DONE;
                  end else begin
                     bit_q <= bit_q + 7'h01;
                     frame_q <= {frame_q[62:0], 1'b1};
                     // Release the line from turnaround onward on reads
                     oe_q <= !rd_op_q || ((bit_q + 7'h01) < MIS_TA_FIRST_BIT);
                  end
               end
            end
            MIS_DONE: begin
               state_q <= MIS_IDLE;
            end
            default: begin
               state_q <= MIS_IDLE;
            end
         endcase
      end
   end

   assign done = (state_q == MIS_DONE);
   assign rd_done = done && rd_op_q;
   assign rdata = rd_q;
   assign mdc = mdc_q;
   assign mdio_o = frame_q[63];
   assign mdio_oe = oe_q;

endmodule : mis_mdio_engine

//--- rtl/mis_regs.sv
// Global interrupt summary and PHY management registers on AHB
`timescale 1ns/100ps
module mis_regs
   import mis_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic soft_rst,
   // AHB slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   // MAC interrupt logic
   input wire logic mac_enabled_irq,
   input wire logic mgmt_complete_irq_enable,
   output logic mgmt_complete_flag,
   output logic mac_irq_line,
   // Management pins
   output logic mdc,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic mdio_i
);

   function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
      hit = (a == off);
   endfunction : hit

   logic wsel_q;
   logic [31:0] waddr_q;
   logic [31:0] rdata_q;
   logic [15:0] cmd_q;
   logic [MIS_DATA_W-1:0] data_q;
   logic busy_q;
   logic gsts_q;
   logic gmsk_q;
   logic lvl_q;
   logic start_q;
   logic wr_cmd;
   logic wr_data;
   logic wr_gsts;
   logic wr_gmsk;
   logic wr_gfrc;
   logic addr_ok;
   logic eng_done;
   logic eng_rd_done;
   logic [MIS_DATA_W-1:0] eng_rdata;
   logic irq_set;
   logic lvl_now;

   // ************************************************************
   // AHB address and data phase
   // ************************************************************
   // Zero wait states; every access completes OKAY, unmapped reads give zero
   // Size is not decoded, so a narrow write still acts on the whole word
   // A read in the data phase of a write sees the old value; leave one idle cycle
   assign hreadyout = 1'b1;
   assign hresp = 2'b00;
   assign addr_ok = hsel && hready && (htrans & MIS_HTRANS_ACTIVE) != 2'b00;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wsel_q <= 1'b0;
         waddr_q <= MIS_RESET_WORD;
      end else begin
         wsel_q <= addr_ok && hwrite;
         waddr_q <= addr_ok ? haddr : waddr_q;
      end
   end

   assign wr_cmd = wsel_q && hit(waddr_q, MIS_ADDR_CMD);
   assign wr_data = wsel_q && hit(waddr_q, MIS_ADDR_DATA);
   assign wr_gsts = wsel_q && hit(waddr_q, MIS_ADDR_GSTS);
   assign wr_gmsk = wsel_q && hit(waddr_q, MIS_ADDR_GMSK);
   assign wr_gfrc = wsel_q && hit(waddr_q, MIS_ADDR_GFRC);

   // Read data is sampled in the address phase; reads have no side effects
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= MIS_RESET_WORD;
      end else if (addr_ok && !hwrite) begin
         rdata_q <= MIS_RESET_WORD;
         if (hit(haddr, MIS_ADDR_CMD)) begin
            rdata_q[15:0] <= cmd_q;
         end else if (hit(haddr, MIS_ADDR_DATA)) begin
            rdata_q[MIS_DATA_W-1:0] <= data_q;
         end else if (hit(haddr, MIS_ADDR_STS)) begin
            rdata_q[MIS_BUSY_BIT] <= busy_q;
         end else if (hit(haddr, MIS_ADDR_GSTS) || hit(haddr, MIS_ADDR_GVIEW)) begin
            rdata_q[MIS_INT_BIT] <= gsts_q;
         end else if (hit(haddr, MIS_ADDR_GMSK)) begin
            rdata_q[MIS_INT_BIT] <= gmsk_q;
         end
         // Force register falls through and reads zero
      end
   end

   assign hrdata = rdata_q;

   // ************************************************************
   // PHY management registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cmd_q <= 16'h0000;
         busy_q <= 1'b0;
         start_q <= 1'b0;
      end else if (soft_rst) begin
         cmd_q <= 16'h0000;
         busy_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         // A command written while busy is dropped so the running frame is safe
         start_q <= wr_cmd && !busy_q;
         if (wr_cmd && !busy_q) begin
            cmd_q <= hwdata[15:0] & MIS_CMD_MASK;
            busy_q <= 1'b1;
         end else if (eng_done) begin
            busy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= 16'h0000;
      end else if (soft_rst) begin
         data_q <= 16'h0000;
      end else if (eng_rd_done) begin
         // Returned PHY data wins over a colliding software write
         data_q <= eng_rdata;
      end else if (wr_data) begin
         data_q <= hwdata[MIS_DATA_W-1:0];
      end
   end

   // An undefined opcode sends no frame but still completes, so busy never sticks
   mis_mdio_engine u_engine (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .soft_rst(soft_rst),
      .start(start_q),
      .op(cmd_q[MIS_OP_HI:MIS_OP_LO]),
      .phy_sel(cmd_q[MIS_PHY_HI:MIS_PHY_LO]),
      .reg_sel(cmd_q[MIS_REG_HI:MIS_REG_LO]),
      .wdata(data_q),
      .done(eng_done),
      .rd_done(eng_rd_done),
      .rdata(eng_rdata),
      .mdc(mdc),
      .mdio_o(mdio_o),
      .mdio_oe(mdio_oe),
      .mdio_i(mdio_i)
   );

   // One-cycle pulse; the MAC status register latches it
   assign mgmt_complete_flag = eng_done;

   // ************************************************************
   // Global interrupt summary
   // ************************************************************
   // Level sources count once per rising edge, so a clear holds until a new event
   // Force and completion sources pass through the mask like any other event
   assign lvl_now = gmsk_q && mac_enabled_irq;
   assign irq_set = gmsk_q && ((lvl_now && !lvl_q)
                    || (eng_done && mgmt_complete_irq_enable)
                    || (wr_gfrc && hwdata[MIS_INT_BIT]));

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gmsk_q <= 1'b0;
         gsts_q <= 1'b0;
         lvl_q <= 1'b0;
      end else if (soft_rst) begin
         gmsk_q <= 1'b0;
         gsts_q <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         lvl_q <= lvl_now;
         if (wr_gmsk) begin
            gmsk_q <= hwdata[MIS_INT_BIT];
         end
         if (irq_set) begin
            gsts_q <= 1'b1;
         end else if (wr_gsts && hwdata[MIS_INT_BIT]) begin
            gsts_q <= 1'b0;
         end else if (!gmsk_q) begin
            // Mask clear drops a pending status so nothing reaches the processor
            gsts_q <= 1'b0;
         end
      end
   end

   // The line is the status bit itself, so they can never disagree
   assign mac_irq_line = gsts_q;

endmodule : mis_regs

//--- tb/mis_regs_chk.sv
// Port checker of the IRQ summary and PHY management registers
`timescale 1ns/100ps
module mis_regs_chk
   import mis_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic soft_rst,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Interrupt and pins
   input wire logic mac_enabled_irq,
   input wire logic mgmt_complete_flag,
   input wire logic mac_irq_line,
   input wire logic mdc,
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   logic wph_q;
   logic [31:0] wad_q;
   logic rd_a;
   assign rd_a = hsel && hready && htrans[1] && !hwrite;
   // Write data only counts in the cycle after its address phase
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wph_q <= 1'b0;
         wad_q <= 32'h0;
      end else begin
         wph_q <= hsel && hready && htrans[1] && hwrite;
         wad_q <= haddr;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b || soft_rst);
   a_line_mirror: assert property (
      rd_a && haddr == MIS_ADDR_GSTS |=> hrdata[15] == $past(mac_irq_line))
      else $error("status read differs from line");
   a_view_match: assert property (
      rd_a && haddr == MIS_ADDR_GVIEW |=> hrdata[15] == $past(mac_irq_line))
      else $error("view read differs from line");
   a_force_zero: assert property (
      rd_a && haddr == MIS_ADDR_GFRC |=> hrdata == 32'h0)
      else $error("force register read not zero");
   a_mask_clear: assert property (
      wph_q && wad_q == MIS_ADDR_GMSK && !hwdata[15] |-> ##2 !mac_irq_line)
      else $error("line high with mask clear");
   a_w1c_clear: assert property (
      wph_q && wad_q == MIS_ADDR_GSTS && hwdata[15] && !mgmt_complete_flag
      && $stable(mac_enabled_irq) |=> !mac_irq_line)
      else $error("write one did not clear status");
   a_flag_pulse: assert property (
      mgmt_complete_flag |=> !mgmt_complete_flag)
      else $error("completion flag longer than one cycle");
   a_preamble_start: assert property (
      $rose(mdio_oe) |-> ((mdio_o && mdio_oe) throughout ##255 1) ##1 !mdio_o)
      else $error("preamble not 32 ones then zero");
   a_mdc_high: assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc)
      else $error("clock high half not 4 cycles");
   a_frame_done: assert property (
      $rose(mdio_oe) |-> ##[510:520] mgmt_complete_flag)
      else $error("frame completion out of window");
   c_frame: cover property ($rose(mdio_oe));
   c_w1c: cover property (wph_q && wad_q == MIS_ADDR_GSTS && hwdata[15]);
   c_view: cover property (rd_a && haddr == MIS_ADDR_GVIEW);
endmodule : mis_regs_chk

bind mis_regs mis_regs_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .soft_rst(soft_rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .mac_enabled_irq(mac_enabled_irq),
   .mgmt_complete_flag(mgmt_complete_flag), .mac_irq_line(mac_irq_line), .mdc(mdc),
   .mdio_o(mdio_o), .mdio_oe(mdio_oe));

//--- tb/mis_phy_model.sv
// Behavioural PHY answering management frames
`timescale 1ns/100ps
module mis_phy_model
(
   // Pins of the block
   input wire logic mdc,
   input wire logic mdio_o,
   input wire logic mdio_oe,
   // Resolved line
   output logic mdio_i
);
   logic [15:0] mem [1024];
   logic [11:0] hdr = 12'h0;
   logic [15:0] wd = 16'h0;
   int ones = 0;
   int idx = 0;
   logic drv = 1'b0;
   logic dval = 1'b0;
   // Line has a pull-up, so a released line reads one
   assign mdio_i = mdio_oe ? mdio_o : (drv ? dval : 1'b1);
   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = 16'(i) ^ 16'hbeef;
      end
   end
   always @(posedge mdc) begin
      if (idx == 0) begin
         ones <= (mdio_oe && mdio_o) ? ones + 1 : 0;
         if (mdio_oe && !mdio_o && ones >= 32) begin
            idx <= 33;
         end
      end else begin
         if (idx < 46) begin
            hdr <= {hdr[10:0], mdio_o};
         end
         wd <= {wd[14:0], mdio_o};
         idx <= (idx == 63) ? 0 : idx + 1;
         if (idx == 63 && hdr[11:10] == 2'b01) begin
            mem[hdr[9:0]] <= {wd[14:0], mdio_o};
         end
      end
   end
   // Drive at the start of each bit so the value is settled at the rising edge
   always @(negedge mdc) begin
      drv <= hdr[11:10] == 2'b10 && idx >= 47;
      dval <= (idx >= 48) ? mem[hdr[9:0]][63-idx] : 1'b0;
   end
endmodule : mis_phy_model

//--- tb/tb_mac_irq_summary_and_phy_mgmt_regs.sv
// Testbench of the IRQ summary and PHY management registers
`timescale 1ns/100ps
module tb_mac_irq_summary_and_phy_mgmt_regs
   import mis_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic soft_rst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic mac_enabled_irq = 1'b0;
   logic mgmt_complete_irq_enable = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic [1:0] hresp;
   logic mgmt_complete_flag, mac_irq_line, mdc, mdio_o, mdio_oe, mdio_i;
   logic [31:0] rv;
   int failures = 0;
   int n_checks = 0;
   int n_cpl = 0;
   always #25 clk_sys = ~clk_sys;
   mis_regs dut (.clk_sys, .rst_b, .soft_rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(1'b1), .hreadyout, .hresp, .hrdata,
      .mac_enabled_irq, .mgmt_complete_irq_enable, .mgmt_complete_flag, .mac_irq_line,
      .mdc, .mdio_o, .mdio_oe, .mdio_i);
   mis_phy_model phy (.mdc, .mdio_o, .mdio_oe, .mdio_i);
   always @(posedge clk_sys) begin
      if (mgmt_complete_flag === 1'b1) begin
         n_cpl++;
      end
   end
   // ********
   // Bus tasks
   // ********
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic close_out;
      if (failures == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b0;
      @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'b00;
      @(posedge clk_sys);
      d = hrdata;
   endtask : rd
   // Polling keeps to the rule that software waits for busy to drop
   task automatic wait_idle;
      for (int i = 0; i < 300; i++) begin
         rd(MIS_ADDR_STS, rv);
         if (rv[0] === 1'b0) return;
      end
      failures++;
      close_out();
   endtask : wait_idle
   // ********
   // Scenarios
   // ********
   task automatic t_rst;
      logic [31:0] a [8] = '{MIS_ADDR_CMD, MIS_ADDR_DATA, MIS_ADDR_STS, MIS_ADDR_GSTS,
         MIS_ADDR_GMSK, MIS_ADDR_GVIEW, MIS_ADDR_GFRC, 32'h8001_0020};
      foreach (a[i]) begin
         rd(a[i], rv);
         chk("reset value", rv, 32'h0);
      end
      chk("hreadyout", {31'h0, hreadyout}, 32'h1);
      chk("hresp", {30'h0, hresp}, 32'h0);
   endtask : t_rst
   task automatic t_irq;
      mac_enabled_irq <= 1'b1;
      wr(MIS_ADDR_GFRC, 32'h8000);
      rd(MIS_ADDR_GSTS, rv);
      chk("masked", rv, 32'h0);
      wr(MIS_ADDR_GMSK, 32'h8000);
      mac_enabled_irq <= 1'b0;
      @(posedge clk_sys);
      mac_enabled_irq <= 1'b1;
      rd(MIS_ADDR_GVIEW, rv);
      chk("view", rv, 32'h8000);
      rd(MIS_ADDR_GSTS, rv);
      chk("status", rv, 32'h8000);
      chk("line", {31'h0, mac_irq_line}, 32'h1);
      wr(MIS_ADDR_GSTS, 32'h8000);
      rd(MIS_ADDR_GSTS, rv);
      chk("w1c", rv, 32'h0);
      wr(MIS_ADDR_GFRC, 32'h0);
      rd(MIS_ADDR_GSTS, rv);
      chk("force zero", rv, 32'h0);
      wr(MIS_ADDR_GFRC, 32'h8000);
      rd(MIS_ADDR_GFRC, rv);
      chk("force read", rv, 32'h0);
      rd(MIS_ADDR_GSTS, rv);
      chk("forced", rv, 32'h8000);
      wr(MIS_ADDR_GMSK, 32'h0);
      mac_enabled_irq <= 1'b0;
      rd(MIS_ADDR_GSTS, rv);
      chk("mask off", rv, 32'h0);
   endtask : t_irq
   task automatic t_soft;
      wr(MIS_ADDR_GMSK, 32'h8000);
      wr(MIS_ADDR_GFRC, 32'h8000);
      soft_rst <= 1'b1;
      @(posedge clk_sys);
      soft_rst <= 1'b0;
      rd(MIS_ADDR_GVIEW, rv);
      chk("soft reset", rv, 32'h0);
      chk("soft line", {31'h0, mac_irq_line}, 32'h0);
      rd(MIS_ADDR_GMSK, rv);
      chk("soft mask", rv, 32'h0);
   endtask : t_soft
   task automatic t_mgmt;
      int n0;
      n0 = n_cpl;
      mgmt_complete_irq_enable <= 1'b1;
      wr(MIS_ADDR_GMSK, 32'h8000);
      wr(MIS_ADDR_DATA, 32'ha5c3);
      wr(MIS_ADDR_CMD, 32'h4065);
      rd(MIS_ADDR_STS, rv);
      chk("busy", rv, 32'h1);
      wr(MIS_ADDR_CMD, 32'h80a3);
      wait_idle();
      rd(MIS_ADDR_CMD, rv);
      chk("cmd while busy", rv, 32'h4065);
      chk("phy write", {16'h0, phy.mem[10'h065]}, 32'ha5c3);
      wr(MIS_ADDR_CMD, 32'h8065);
      wait_idle();
      rd(MIS_ADDR_DATA, rv);
      chk("read back", rv, 32'ha5c3);
      wr(MIS_ADDR_CMD, 32'h80a3);
      wait_idle();
      rd(MIS_ADDR_DATA, rv);
      chk("read other", rv, {16'h0, 16'hbeef ^ 16'h00a3});
      wr(MIS_ADDR_CMD, 32'h0);
      wait_idle();
      chk("completions", 32'(n_cpl - n0), 32'h4);
      rd(MIS_ADDR_GSTS, rv);
      chk("mgmt irq", rv, 32'h8000);
   endtask : t_mgmt
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_rst();
      t_irq();
      t_soft();
      t_mgmt();
      close_out();
   end
endmodule : tb_mac_irq_summary_and_phy_mgmt_regs
